// ==== common/mcadc_consts.svh ====
// Constants of the multichannel converter parallel interface
// Function
// - Low eight data lines are two-way; upper six lines only drive results.
// - All data lines float whenever read strobe or chip select is high.
// - Enable bit n switches input n on when one, off when zero.
// - Enable bits above the implemented inputs are ignored.
// - Enable bits are captured on the rising store strobe edge with select low.
// - A new enable mask only applies from the next sample start event.
// - Power-down entry or exit leaves the enable register untouched.
// - After power-up the enable register selects all eight inputs.
// - Inputs track while sample start is low; conversion starts on its rise.
// - Result-ready flag pulses low once per result until the sequence ends.
// - Last-result flag goes low when the final result is available.
// - First result at 17th conversion clock, then every third clock.
// - Read strobe low drives the current result; high releases the bus.
// - With eight inputs the last flag falls on clock 38; reads step through.
// - Last result ready 17 plus 3 times (N minus 1) clocks after start.
// - Keep-all-powered high powers every input, low only enabled ones.
// - Power-down high puts the converter into its power-down state.
// - Clock source select high picks the internal clock, low the external.
`ifndef MCADC_CONSTS_SVH
`define MCADC_CONSTS_SVH

// ****************************************************************
// Register and data layout
// ****************************************************************
`define MCADC_NUM_CH 8
`define MCADC_RES_W 14
`define MCADC_LO_W 8
`define MCADC_HI_W 6
`define MCADC_MASK_RESET 8'hff
`define MCADC_IMPL_ALL 8'hff

// ****************************************************************
// Timing
// ****************************************************************
`define MCADC_SYS_HZ 40000000
`define MCADC_INT_CONV_HZ 10000000
`define MCADC_FIRST_TICK 6'h11
`define MCADC_NEXT_TICKS 6'h03

// ****************************************************************
// Pin idle levels: {start, select, read, store, ext clk, pd, keep on, src}
// ****************************************************************
`define MCADC_CTL_W 8
`define MCADC_CTL_IDLE 8'hf0
`define MCADC_DATA_IDLE 8'h00
`define MCADC_CTL_START 7
`define MCADC_CTL_SEL 6
`define MCADC_CTL_RD 5
`define MCADC_CTL_WR 4
`define MCADC_CTL_EXT 3
`define MCADC_CTL_PD 2
`define MCADC_CTL_KEEP 1
`define MCADC_CTL_SRC 0

`endif

// ==== common/mcadc_pkg.sv ====
// Sequencer state type of the converter interface top module
package mcadc_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONV, ST_DONE} mcadc_state_e;
endpackage

// ==== hw/mcadc_sync.sv ====
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/1ps
module mcadc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] IDLE = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins and settled values
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// The first stage feeds only the second
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
			q <= IDLE;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q <= (agree & s3_q) | (~agree & q);
		end
	end
endmodule

// ==== hw/mcadc_buf2.sv ====
// Small result buffer with valid and ready on both sides
`timescale 1ns/1ps
module mcadc_buf2 #(
	parameter int W = 15,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==== hw/mcadc_top.sv ====
// Digital side of the simultaneous-sampling converter: bus, sequencing, flags
`timescale 1ns/1ps
`include "mcadc_consts.svh"
module mcadc_top #(
	parameter int NUM_IMPL = `MCADC_NUM_CH,
	parameter int SYS_HZ = `MCADC_SYS_HZ,
	parameter int INT_CONV_HZ = `MCADC_INT_CONV_HZ,
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// Host control pins
	input wire logic CHIP_SELECT_N,
	input wire logic READ_STROBE_N,
	input wire logic STORE_STROBE_N,
	input wire logic SAMPLE_START_N,
	// Mode pins
	input wire logic POWER_DOWN_IN,
	input wire logic KEEP_ALL_POWERED,
	input wire logic CLOCK_SOURCE_SELECT,
	input wire logic EXT_CONV_CLK,
	// Data bus, low lines two-way
	input wire logic [`MCADC_LO_W-1:0] LOW_DATA_LINES_IN,
	output logic [`MCADC_LO_W-1:0] LOW_DATA_LINES_OUT,
	output logic LOW_DATA_LINES_OE,
	output logic [`MCADC_HI_W-1:0] HIGH_DATA_LINES_OUT,
	output logic HIGH_DATA_LINES_OE,
	// Status flags
	output logic RESULT_READY_FLAG_N,
	output logic LAST_RESULT_FLAG_N,
	// Analog core control
	output logic TRACK_HOLD,
	output logic [2:0] CONV_CHANNEL,
	input wire logic [`MCADC_RES_W-1:0] CONV_RESULT,
	output logic [`MCADC_NUM_CH-1:0] CHANNEL_POWER,
	output logic CORE_POWER_DOWN
);
	localparam int INT_DIV = SYS_HZ / INT_CONV_HZ;
	localparam int DW = (INT_DIV > 1) ? $clog2(INT_DIV) : 1;
	localparam int BW = `MCADC_RES_W + 1;
	localparam logic [`MCADC_NUM_CH-1:0] IMPL_MASK =
		`MCADC_NUM_CH'((`MCADC_NUM_CH+1)'(1) << NUM_IMPL) - 1'b1;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [`MCADC_CTL_W-1:0] ctl_pins;
	logic [`MCADC_CTL_W-1:0] ctl_s;
	logic [`MCADC_CTL_W-1:0] ctl_prev_q;
	logic [`MCADC_LO_W-1:0] data_s;

	assign ctl_pins = {SAMPLE_START_N, CHIP_SELECT_N, READ_STROBE_N, STORE_STROBE_N,
		EXT_CONV_CLK, POWER_DOWN_IN, KEEP_ALL_POWERED, CLOCK_SOURCE_SELECT};

	mcadc_sync #(.W(`MCADC_CTL_W), .IDLE(`MCADC_CTL_IDLE)) u_ctl_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.d(ctl_pins),
		.q(ctl_s)
	);

	mcadc_sync #(.W(`MCADC_LO_W), .IDLE(`MCADC_DATA_IDLE)) u_data_sync (
		.clk(CLK_SYS),
		.srst(SRST),
		.d(LOW_DATA_LINES_IN),
		.q(data_s)
	);

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ctl_prev_q <= `MCADC_CTL_IDLE;
		end else begin
			ctl_prev_q <= ctl_s;
		end
	end

	// ****************************************************************
	// Decoded pin levels and edges
	// ****************************************************************
	wire start_n = ctl_s[`MCADC_CTL_START];
	wire cs_n = ctl_s[`MCADC_CTL_SEL];
	wire rd_n = ctl_s[`MCADC_CTL_RD];
	wire wr_n = ctl_s[`MCADC_CTL_WR];
	wire ext_clk = ctl_s[`MCADC_CTL_EXT];
	wire pd = ctl_s[`MCADC_CTL_PD];
	wire keep_on = ctl_s[`MCADC_CTL_KEEP];
	wire int_src = ctl_s[`MCADC_CTL_SRC];
	wire start_fall = ctl_prev_q[`MCADC_CTL_START] & ~start_n;
	wire start_rise = ~ctl_prev_q[`MCADC_CTL_START] & start_n;
	wire wr_rise = ~ctl_prev_q[`MCADC_CTL_WR] & wr_n;
	wire ext_rise = ~ctl_prev_q[`MCADC_CTL_EXT] & ext_clk;
	wire rd_act = ~cs_n & ~rd_n;
	wire rd_act_prev = ~ctl_prev_q[`MCADC_CTL_SEL] & ~ctl_prev_q[`MCADC_CTL_RD];
	wire rd_begin = rd_act & ~rd_act_prev;
	wire rd_end = ~rd_act & rd_act_prev;

	// ****************************************************************
	// Enable register
	// ****************************************************************
	logic [`MCADC_NUM_CH-1:0] mask_q;
	logic [`MCADC_NUM_CH-1:0] active_q;

	// Power-down does not touch the mask; only a store or reset does
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mask_q <= `MCADC_MASK_RESET;
		end else if (wr_rise && !cs_n) begin
			mask_q <= data_s;
		end
	end

	// ****************************************************************
	// Conversion clock tick
	// ****************************************************************
	logic [DW-1:0] div_q;
	wire int_tick = (div_q == '0);
	wire conv_tick = int_src ? int_tick : ext_rise;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			div_q <= '0;
		end else begin
			div_q <= (div_q == DW'(INT_DIV-1)) ? '0 : div_q + 1'b1;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	mcadc_pkg::mcadc_state_e state_q;
	mcadc_pkg::mcadc_state_e state_d;
	logic [`MCADC_NUM_CH-1:0] pend_q;
	logic [5:0] tick_q;
	logic [5:0] due_q;
	logic [2:0] cur_ch;
	logic buf_in_ready;
	logic buf_out_valid;
	logic [BW-1:0] buf_out_data;

	function automatic logic [2:0] lowest(input logic [`MCADC_NUM_CH-1:0] m);
		logic [2:0] idx;
		idx = '0;
		for (int i = `MCADC_NUM_CH-1; i >= 0; i--) begin
			if (m[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	assign cur_ch = lowest(pend_q);
	wire [5:0] tick_nx = tick_q + 6'h01;
	wire due_hit = (state_q == mcadc_pkg::ST_CONV) && conv_tick && (tick_nx == due_q);
	// A result that finds the buffer full waits; the tick count halts with it
	wire push = due_hit && buf_in_ready;
	wire [`MCADC_NUM_CH-1:0] pend_left = pend_q & ~(`MCADC_NUM_CH'(1) << cur_ch);
	wire push_last = (pend_left == '0);
	wire [`MCADC_NUM_CH-1:0] sel_mask = mask_q & IMPL_MASK;

	always_comb begin
		state_d = state_q;
		case (state_q)
			mcadc_pkg::ST_IDLE: begin
				if (start_fall) begin
					state_d = mcadc_pkg::ST_TRACK;
				end
			end
			mcadc_pkg::ST_TRACK: begin
				if (start_rise) begin
					state_d = (active_q == '0) ? mcadc_pkg::ST_DONE : mcadc_pkg::ST_CONV;
				end
			end
			mcadc_pkg::ST_CONV: begin
				if (push && push_last) begin
					state_d = mcadc_pkg::ST_DONE;
				end
			end
			mcadc_pkg::ST_DONE: begin
				if (start_fall) begin
					state_d = mcadc_pkg::ST_TRACK;
				end
			end
			default: begin
				state_d = mcadc_pkg::ST_IDLE;
			end
		endcase
		if (pd) begin
			state_d = mcadc_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_q <= mcadc_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			active_q <= `MCADC_MASK_RESET;
			pend_q <= '0;
			tick_q <= '0;
			due_q <= `MCADC_FIRST_TICK;
		end else if (start_fall && state_d == mcadc_pkg::ST_TRACK) begin
			active_q <= sel_mask;
		end else if (state_q == mcadc_pkg::ST_TRACK && start_rise) begin
			pend_q <= active_q;
			tick_q <= '0;
			due_q <= `MCADC_FIRST_TICK;
		end else if (push) begin
			pend_q <= pend_left;
			tick_q <= tick_nx;
			due_q <= due_q + `MCADC_NEXT_TICKS;
		end else if (state_q == mcadc_pkg::ST_CONV && conv_tick && !due_hit) begin
			tick_q <= tick_nx;
		end
	end

	// ****************************************************************
	// Result buffer and result store
	// ****************************************************************
	logic [`MCADC_RES_W-1:0] res_mem [`MCADC_NUM_CH];
	logic [3:0] wr_cnt_q;
	logic [2:0] rd_ptr_q;
	wire store_ready = (wr_cnt_q != 4'(`MCADC_NUM_CH));
	wire store = buf_out_valid && store_ready;
	wire seq_start = (state_q == mcadc_pkg::ST_TRACK) && start_rise;

	mcadc_buf2 #(.W(BW), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(CLK_SYS),
		.srst(SRST),
		.in_valid(due_hit),
		.in_ready(buf_in_ready),
		.in_data({push_last, CONV_RESULT}),
		.out_valid(buf_out_valid),
		.out_ready(store_ready),
		.out_data(buf_out_data)
	);

	always_ff @(posedge CLK_SYS) begin
		if (store) begin
			res_mem[wr_cnt_q[2:0]] <= buf_out_data[`MCADC_RES_W-1:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST || seq_start) begin
			wr_cnt_q <= '0;
		end else if (store) begin
			wr_cnt_q <= wr_cnt_q + 4'h1;
		end
	end

	// ****************************************************************
	// Flags
	// ****************************************************************
	logic rdy_n_q;
	logic last_n_q;

	// Ready flag stays low until the next conversion clock tick so a slow host sees it
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			rdy_n_q <= 1'b1;
			last_n_q <= 1'b1;
		end else begin
			if (store) begin
				rdy_n_q <= 1'b0;
			end else if (conv_tick) begin
				rdy_n_q <= 1'b1;
			end
			if (store && buf_out_data[BW-1]) begin
				last_n_q <= 1'b0;
			end else if (seq_start && active_q == '0) begin
				last_n_q <= 1'b0;
			end else if (start_fall || pd) begin
				last_n_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [`MCADC_RES_W-1:0] dout_q;
	logic oe_q;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			dout_q <= '0;
			oe_q <= 1'b0;
			rd_ptr_q <= '0;
		end else begin
			oe_q <= rd_act;
			if (rd_begin) begin
				dout_q <= res_mem[rd_ptr_q];
			end
			if (seq_start) begin
				rd_ptr_q <= '0;
			end else if (rd_end) begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
			end
		end
	end

	// ****************************************************************
	// Analog core control
	// ****************************************************************
	logic track_q;
	logic [2:0] conv_ch_q;
	logic [`MCADC_NUM_CH-1:0] ch_pwr_q;
	logic pd_q;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			track_q <= 1'b0;
			conv_ch_q <= '0;
			ch_pwr_q <= '0;
			pd_q <= 1'b0;
		end else begin
			track_q <= (state_d == mcadc_pkg::ST_TRACK);
			conv_ch_q <= (state_d == mcadc_pkg::ST_CONV) ? lowest(pend_q) : '0;
			pd_q <= pd;
			if (pd) begin
				ch_pwr_q <= '0;
			end else if (keep_on) begin
				ch_pwr_q <= IMPL_MASK;
			end else begin
				ch_pwr_q <= active_q;
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign LOW_DATA_LINES_OUT = dout_q[`MCADC_LO_W-1:0];
	assign HIGH_DATA_LINES_OUT = dout_q[`MCADC_RES_W-1:`MCADC_LO_W];
	assign LOW_DATA_LINES_OE = oe_q;
	assign HIGH_DATA_LINES_OE = oe_q;
	assign RESULT_READY_FLAG_N = rdy_n_q;
	assign LAST_RESULT_FLAG_N = last_n_q;
	assign TRACK_HOLD = track_q;
	assign CONV_CHANNEL = conv_ch_q;
	assign CHANNEL_POWER = ch_pwr_q;
	assign CORE_POWER_DOWN = pd_q;
endmodule

// ==== sim/mcadc_chk.sv ====
// Pin-level concurrent checks of the converter interface
`timescale 1ns/1ps
module mcadc_chk #(
	parameter int NUM_IMPL = 8
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SRST,
	// Host pins
	input wire logic READ_STROBE_N,
	input wire logic SAMPLE_START_N,
	input wire logic POWER_DOWN_IN,
	input wire logic KEEP_ALL_POWERED,
	// Device outputs
	input wire logic [7:0] LOW_DATA_LINES_OUT,
	input wire logic LOW_DATA_LINES_OE,
	input wire logic [5:0] HIGH_DATA_LINES_OUT,
	input wire logic HIGH_DATA_LINES_OE,
	input wire logic RESULT_READY_FLAG_N,
	input wire logic LAST_RESULT_FLAG_N,
	input wire logic TRACK_HOLD,
	input wire logic [2:0] CONV_CHANNEL,
	input wire logic [7:0] CHANNEL_POWER,
	input wire logic CORE_POWER_DOWN
);
	localparam logic [7:0] IMPL = 8'((1 << NUM_IMPL) - 1);
	// ****************************************
	// Properties
	// ****************************************
	// Repetition counts cover the pin synchronisers plus one register stage
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (SRST);
	property p_oe_pair; LOW_DATA_LINES_OE == HIGH_DATA_LINES_OE; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("Data enables differ");
	property p_release; READ_STROBE_N [*6] |-> !LOW_DATA_LINES_OE; endproperty
	a_release: assert property (p_release) else $error("Bus not released");
	property p_hold; LOW_DATA_LINES_OE && $past(LOW_DATA_LINES_OE) |->
		$stable(LOW_DATA_LINES_OUT) && $stable(HIGH_DATA_LINES_OUT); endproperty
	a_hold: assert property (p_hold) else $error("Result moved during read");
	property p_track; SAMPLE_START_N [*8] |-> !TRACK_HOLD; endproperty
	a_track: assert property (p_track) else $error("Tracking with start high");
	property p_last; $fell(LAST_RESULT_FLAG_N) |-> !RESULT_READY_FLAG_N; endproperty
	a_last: assert property (p_last) else $error("Last flag without result");
	property p_pd; POWER_DOWN_IN [*7] |-> CORE_POWER_DOWN && CHANNEL_POWER == 8'h00;
	endproperty
	a_pd: assert property (p_pd) else $error("Power-down not applied");
	property p_keep_on; (KEEP_ALL_POWERED && !POWER_DOWN_IN) [*7] |->
		(CHANNEL_POWER & IMPL) == IMPL; endproperty
	a_keep_on: assert property (p_keep_on) else $error("Inputs left unpowered");
	property p_asc; $changed(CONV_CHANNEL) && CONV_CHANNEL != 3'h0 |->
		CONV_CHANNEL > $past(CONV_CHANNEL); endproperty
	a_asc: assert property (p_asc) else $error("Channel order broken");
endmodule

bind mcadc_top mcadc_chk #(.NUM_IMPL(NUM_IMPL)) u_chk (
	.CLK_SYS(CLK_SYS), .SRST(SRST), .READ_STROBE_N(READ_STROBE_N),
	.SAMPLE_START_N(SAMPLE_START_N), .POWER_DOWN_IN(POWER_DOWN_IN),
	.KEEP_ALL_POWERED(KEEP_ALL_POWERED), .LOW_DATA_LINES_OUT(LOW_DATA_LINES_OUT),
	.LOW_DATA_LINES_OE(LOW_DATA_LINES_OE), .HIGH_DATA_LINES_OUT(HIGH_DATA_LINES_OUT),
	.HIGH_DATA_LINES_OE(HIGH_DATA_LINES_OE), .RESULT_READY_FLAG_N(RESULT_READY_FLAG_N),
	.LAST_RESULT_FLAG_N(LAST_RESULT_FLAG_N), .TRACK_HOLD(TRACK_HOLD),
	.CONV_CHANNEL(CONV_CHANNEL), .CHANNEL_POWER(CHANNEL_POWER),
	.CORE_POWER_DOWN(CORE_POWER_DOWN)
);

// ==== sim/mcadc_far_model.sv ====
// Far-side model: analog core codes, external conversion clock, data wire
`timescale 1ns/1ps
module mcadc_far_model (
	// Clock
	input wire logic clk,
	// Data lines
	input wire logic [7:0] dev_out,
	input wire logic dev_oe,
	input wire logic [7:0] host_d,
	input wire logic host_oe,
	output logic [7:0] wire_lvl,
	// Analog core
	input wire logic [2:0] channel,
	input wire logic [13:0] base,
	output logic [13:0] result,
	// External conversion clock
	input wire logic ext_run,
	output logic ext_clk
);
	logic [7:0] last_q = 8'h00;
	// No pull on these lines: undriven shows the inverse of the last level
	assign wire_lvl = dev_oe ? dev_out : (host_oe ? host_d : ~last_q);
	always_ff @(posedge clk) begin
		if (dev_oe || host_oe) begin
			last_q <= wire_lvl;
		end
	end
	// Each input gets its own code so order and bit placement show in reads
	assign result = base + 14'(channel) * 14'h0421;
	// 2.5 MHz, first edge 200 ns after start; stands low between frames
	initial begin
		ext_clk = 1'b0;
		forever begin
			if (ext_run) begin // Rate and first-edge delay kept
				#200 ext_clk = 1'b1;
				#200 ext_clk = 1'b0;
			end else begin
				#25;
			end
		end
	end
endmodule

// ==== sim/test_mcadc_top.sv ====
// Self-checking bench: pin-level host against a queue model of the results
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("FAIL %0t got %0h exp %0h", $time, g, e); end end
module test_mcadc_top;
	localparam int TICK3 = 3 * (40000000 / 10000000);
	logic CLK_SYS = 1'b0;
	logic SRST = 1'b1;
	logic CHIP_SELECT_N = 1'b1;
	logic READ_STROBE_N = 1'b1;
	logic STORE_STROBE_N = 1'b1;
	logic SAMPLE_START_N = 1'b1;
	logic POWER_DOWN_IN = 1'b0;
	logic KEEP_ALL_POWERED = 1'b0;
	logic CLOCK_SOURCE_SELECT = 1'b1;
	logic EXT_CONV_CLK, LOW_DATA_LINES_OE, HIGH_DATA_LINES_OE, TRACK_HOLD, CORE_POWER_DOWN;
	logic RESULT_READY_FLAG_N, LAST_RESULT_FLAG_N;
	logic ext_run = 1'b0;
	logic host_oe = 1'b0;
	logic rdy_prev = 1'b1;
	logic [7:0] host_d = 8'h00;
	logic [7:0] model_mask = 8'hff;
	logic [7:0] LOW_DATA_LINES_IN, LOW_DATA_LINES_OUT, CHANNEL_POWER, m1, m2;
	logic [5:0] HIGH_DATA_LINES_OUT;
	logic [2:0] CONV_CHANNEL;
	logic [13:0] CONV_RESULT;
	logic [13:0] base = 14'h0000;
	logic [13:0] exp_q[$];
	int rdy_cyc[$];
	int rdy_ext[$];
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int ext_cnt = 0;
	int ext0 = 0;
	int seed;

	mcadc_top dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .CHIP_SELECT_N(CHIP_SELECT_N),
		.READ_STROBE_N(READ_STROBE_N), .STORE_STROBE_N(STORE_STROBE_N),
		.SAMPLE_START_N(SAMPLE_START_N), .POWER_DOWN_IN(POWER_DOWN_IN),
		.KEEP_ALL_POWERED(KEEP_ALL_POWERED), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
		.EXT_CONV_CLK(EXT_CONV_CLK), .LOW_DATA_LINES_IN(LOW_DATA_LINES_IN),
		.LOW_DATA_LINES_OUT(LOW_DATA_LINES_OUT), .LOW_DATA_LINES_OE(LOW_DATA_LINES_OE),
		.HIGH_DATA_LINES_OUT(HIGH_DATA_LINES_OUT), .HIGH_DATA_LINES_OE(HIGH_DATA_LINES_OE),
		.RESULT_READY_FLAG_N(RESULT_READY_FLAG_N), .LAST_RESULT_FLAG_N(LAST_RESULT_FLAG_N),
		.TRACK_HOLD(TRACK_HOLD), .CONV_CHANNEL(CONV_CHANNEL), .CONV_RESULT(CONV_RESULT),
		.CHANNEL_POWER(CHANNEL_POWER), .CORE_POWER_DOWN(CORE_POWER_DOWN));
	mcadc_far_model far (.clk(CLK_SYS), .dev_out(LOW_DATA_LINES_OUT),
		.dev_oe(LOW_DATA_LINES_OE), .host_d(host_d), .host_oe(host_oe),
		.wire_lvl(LOW_DATA_LINES_IN), .channel(CONV_CHANNEL), .base(base),
		.result(CONV_RESULT), .ext_run(ext_run), .ext_clk(EXT_CONV_CLK));

	initial begin
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge EXT_CONV_CLK) ext_cnt++;
	// Timestamps of every ready-flag fall, in system cycles and external clocks
	always @(negedge CLK_SYS) begin
		cyc++;
		if (rdy_prev === 1'b1 && RESULT_READY_FLAG_N === 1'b0) begin
			rdy_cyc.push_back(cyc);
			rdy_ext.push_back(ext_cnt - ext0);
		end
		rdy_prev = RESULT_READY_FLAG_N;
	end

	// ****************************************
	// Host tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask
	task automatic finish_test();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Data held six cycles around the strobe rise to clear the synchronisers
	task automatic write_mask(input logic [7:0] m, input logic sel_n);
		tick(1);
		CHIP_SELECT_N = sel_n;
		STORE_STROBE_N = 1'b0;
		host_d = m;
		host_oe = 1'b1;
		tick(6);
		STORE_STROBE_N = 1'b1; // Captured on the rise only when selected
		tick(6);
		CHIP_SELECT_N = 1'b1;
		host_oe = 1'b0;
		if (!sel_n) model_mask = m;
	endtask
	task automatic read_word(output logic [13:0] v);
		int n;
		READ_STROBE_N = 1'b0;
		CHIP_SELECT_N = 1'b0; // Select moves with the read strobe
		n = 0;
		while (LOW_DATA_LINES_OE !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		`CHK(LOW_DATA_LINES_OE, 1'b1) // Bus driven on read
		v = {HIGH_DATA_LINES_OUT, LOW_DATA_LINES_IN};
		READ_STROBE_N = 1'b1;
		CHIP_SELECT_N = 1'b1;
		tick(7);
		`CHK({LOW_DATA_LINES_OE, HIGH_DATA_LINES_OE}, 2'b00) // Released
	endtask
	task automatic run_seq(input logic ext, input logic mid);
		logic [13:0] v;
		logic [7:0] act;
		int n;
		base = 14'($urandom);
		act = model_mask;
		exp_q.delete();
		rdy_cyc.delete();
		rdy_ext.delete();
		for (int c = 0; c < 8; c++) begin
			if (act[c]) exp_q.push_back(base + 14'(c) * 14'h0421); // Order
		end
		CLOCK_SOURCE_SELECT = !ext; // Clock source choice
		tick(4);
		SAMPLE_START_N = 1'b0; // Bus left idle through tracking
		tick(10);
		`CHK(TRACK_HOLD, 1'b1) // Tracking while start is low
		SAMPLE_START_N = 1'b1; // Stays high until the last read
		ext_run = ext;
		ext0 = ext_cnt;
		if (mid) write_mask(m2, 1'b0); // Written during conversion
		n = 0;
		while (LAST_RESULT_FLAG_N !== 1'b0 && n < 2000) begin // Reads wait for the last flag
			tick(1);
			n++;
		end
		`CHK(LAST_RESULT_FLAG_N, 1'b0) // Last flag reached in time
		tick(2);
		ext_run = 1'b0;
		`CHK(rdy_cyc.size(), exp_q.size()) // One pulse per result
		for (int k = 0; k < rdy_cyc.size(); k++) begin
			if (ext) `CHK(rdy_ext[k], 17 + 3 * k) // Clock counts
			else if (k > 0) `CHK(rdy_cyc[k] - rdy_cyc[k - 1], TICK3) // Spacing
		end
		`CHK(CHANNEL_POWER, KEEP_ALL_POWERED ? 8'hff : act) // Power
		foreach (exp_q[k]) begin
			read_word(v);
			`CHK(v, exp_q[k]) // Results in turn
		end
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		seed = $urandom(32'h8542);
		tick(5);
		SRST = 1'b0;
		tick(40000); // Wake-up time after power-up
		ext_run = 1'b1;
		while (ext_cnt < 20) tick(1); // Twenty clocks before the first start
		ext_run = 1'b0;
		tick(80); // Start held high for 2 us
		run_seq(1'b0, 1'b0); // All eight selected by default
		m1 = 8'($urandom_range(254, 1));
		m2 = ~m1;
		write_mask(m1, 1'b0); // Selection before conversion
		run_seq(1'b1, 1'b1);
		write_mask(m1, 1'b1);
		POWER_DOWN_IN = 1'b1;
		tick(10);
		`CHK(CORE_POWER_DOWN, 1'b1) // Power-down reaches the core
		POWER_DOWN_IN = 1'b0;
		tick(10);
		`CHK(CORE_POWER_DOWN, 1'b0) // Core wakes when power-down drops
		run_seq(1'b0, 1'b0); // Mask survives power-down, ignored write
		KEEP_ALL_POWERED = 1'b1;
		run_seq(1'b1, 1'b0);
		finish_test();
	end
	initial begin
		tick(50000);
		err_count++;
		$display("FAIL %0t watchdog expired", $time);
		finish_test();
	end
endmodule
